//--- hdl/wake_pkg.sv
`default_nettype none
package wake_pkg;

  // ==========================================================
  // clock and time base
  localparam int MCLK_HZ = 25000000;
  localparam int RC_HZ = 32768;
  localparam int UNIT_TICKS = 4;
  localparam int CAL_TICKS = 32;
  localparam int CAL_EXPECT = CAL_TICKS * MCLK_HZ / RC_HZ;

  // ==========================================================
  // register offsets
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_EXPONENT = 4'h1;
  localparam logic [3:0] OFS_MANT_HI = 4'h2;
  localparam logic [3:0] OFS_MANT_LO = 4'h3;
  localparam logic [3:0] OFS_LISTEN = 4'h4;
  localparam logic [3:0] OFS_BATT_THR = 4'h5;
  localparam logic [3:0] OFS_INT_EN = 4'h6;
  localparam logic [3:0] OFS_INT_STATUS = 4'h7;
  localparam logic [3:0] OFS_FAST_STATUS = 4'h8;
  localparam logic [3:0] OFS_COMMAND = 4'h9;
  localparam logic [3:0] OFS_STATE = 4'ha;
  localparam logic [3:0] OFS_CLK_SRC = 4'hb;

  // ==========================================================
  // field positions
  localparam int CFG_ENABLE = 0;
  localparam int CFG_CAL = 1;
  localparam int CFG_BATT = 2;
  localparam int CFG_LISTEN = 3;
  localparam int CFG_BATT_PIN = 4;
  localparam int CFG_RECAL_LSB = 5;
  localparam int ST_WAKE = 0;
  localparam int ST_BATT = 1;
  localparam int CMD_BOOT = 0;

  // ==========================================================
  // values after reset
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [3:0] EXPONENT_RST = 4'h0;
  localparam logic [15:0] MANT_RST = 16'h0001;
  localparam logic [7:0] LISTEN_RST = 8'h01;
  localparam logic [4:0] BATT_THR_RST = 5'h00;
  localparam logic [1:0] INT_EN_RST = 2'h0;
  localparam logic [6:0] TRIM_RST = 7'h40;

  // ==========================================================
  // state encodings
  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_WINDOW = 2'b01,
    L_EXTEND = 2'b10
  } listen_e;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_XO_WAIT = 2'b01,
    C_MEASURE = 2'b10
  } cal_e;

endpackage : wake_pkg
`default_nettype wire

//--- hdl/rc_cal.sv
`default_nettype none
module rc_cal
  import wake_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  // request
  input wire logic start,
  output logic busy,
  // oscillators
  input wire logic rc_tick,
  input wire logic xo_ready,
  output logic xo_en,
  output logic [6:0] trim
);

  typedef struct packed {
    cal_e state;
    logic [5:0] ticks;
    logic [COUNT_W-1:0] count;
    logic [6:0] trim;
  } cal_s;

  localparam logic [5:0] LAST_TICK = 6'(CAL_TICKS - 1);
  localparam logic [COUNT_W-1:0] EXPECT = COUNT_W'(CAL_EXPECT);

  cal_s st;
  cal_s next_st;

  // ==========================================================
  // measure rc period against the crystal-derived clock
  always_comb begin
    next_st = st;
    case (st.state)
      C_IDLE: begin
        if (start) begin
          next_st.state = C_XO_WAIT;
        end
      end
      C_XO_WAIT: begin
        next_st.ticks = '0;
        next_st.count = '0;
        if (xo_ready && rc_tick) begin
          next_st.state = C_MEASURE;
        end
      end
      C_MEASURE: begin
        if (st.count != '1) begin
          next_st.count = st.count + 1'b1;
        end
        if (rc_tick) begin
          next_st.ticks = st.ticks + 1'b1;
          if (st.ticks == LAST_TICK) begin
            // too many reference cycles: rc runs slow, speed it up
            if (st.count > EXPECT && st.trim != '1) begin
              next_st.trim = st.trim + 1'b1;
            end else if (st.count < EXPECT && st.trim != '0) begin
              next_st.trim = st.trim - 1'b1;
            end
            next_st.state = C_IDLE;
          end
        end
      end
      default: begin
        next_st.state = C_IDLE;
      end
    endcase
    if (clear) begin
      next_st = '{C_IDLE, 6'h00, '0, TRIM_RST};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '{C_IDLE, 6'h00, '0, TRIM_RST};
    end else begin
      st <= next_st;
    end
  end

  assign busy = (st.state != C_IDLE);
  assign xo_en = (st.state != C_IDLE);
  assign trim = st.trim;

  // ==========================================================
  // checks
  a_cal_xo_start: assert property (@(posedge clk) disable iff (rst)
    (st.state == C_IDLE && start && !clear) |=> xo_en)
    else $error("crystal not started for calibration");

  a_cal_no_measure: assert property (@(posedge clk) disable iff (rst)
    (st.state == C_XO_WAIT && !xo_ready && !clear) |=> (st.state == C_XO_WAIT))
    else $error("measurement without crystal");

endmodule : rc_cal
`default_nettype wire

//--- hdl/wake_timer.sv
`default_nettype none
// Operation
// - count on selected 32 kHz tick source
// - enabled timer keeps counting through sleep
// - period is mantissa times 4 shl exponent
// - expiry raises interrupt when interrupt-enabled
// - calibrate at boot command and shutdown exit
// - periodic recalibration only when enabled, interval
// - calibration starts crystal, compares, trims rc
// - window is setting times 4 shl exponent
// - listen mode opens receive every wake period
// - no preamble: return idle at window end
// - preamble seen extends window for packet
// - at most two windows, then back idle
// - battery monitor only with timer enabled
// - compare battery with threshold at expiry
// - threshold code steps 50 mV, 1.5-3.05 V
// - low battery via interrupt or direct pin
// - interrupt output low while enabled event pending
// - shutdown high clears everything, stops operation
module wake_timer
  import wake_pkg::*;
#(
  parameter int EXP_W = 4,
  parameter int PRE_W = 20
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // time base
  input wire logic RC_TICK,
  input wire logic XTAL_TICK,
  // power
  input wire logic SHUTDOWN,
  // receiver
  input wire logic PREAMBLE_OK,
  input wire logic PKT_DONE,
  output logic RX_ON,
  // battery
  input wire logic [4:0] BATT_LEVEL,
  output logic LOW_BATT,
  // calibration
  input wire logic XO_READY,
  output logic XO_EN,
  output logic [6:0] RC_TRIM,
  // interrupt
  output logic IRQ_N
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] cfg;
    logic clk_src;
    logic [EXP_W-1:0] exponent;
    logic [15:0] mantissa;
    logic [7:0] window;
    logic [4:0] thr;
    logic [1:0] int_en;
    logic [1:0] status;
    logic [7:0] rdata;
    logic [PRE_W-1:0] pre;
    logic [15:0] mcnt;
    listen_e lst;
    logic [7:0] wcnt;
    logic seen;
    logic batt_low;
    logic [7:0] recal_cnt;
    logic cal_pend;
    logic shut_q;
  } wake_s;

  localparam wake_s RST_ST = '{
    cfg: CONFIG_RST, clk_src: 1'b0, exponent: EXP_W'(EXPONENT_RST),
    mantissa: MANT_RST, window: LISTEN_RST, thr: BATT_THR_RST,
    int_en: INT_EN_RST, status: 2'b00, rdata: 8'h00, pre: '0,
    mcnt: 16'h0000, lst: L_IDLE, wcnt: 8'h00, seen: 1'b0,
    batt_low: 1'b0, recal_cnt: 8'h00, cal_pend: 1'b0, shut_q: 1'b0};

  wake_s st;
  wake_s next_st;

  logic tick;
  logic [PRE_W-1:0] unit_len;
  logic unit;
  logic expire;
  logic window_end;
  logic cal_start;
  logic cal_busy;
  logic [1:0] rd_clear;
  logic [1:0] set_flags;
  logic [7:0] recal_last;

  // ==========================================================
  // time base and wake counter
  assign tick = st.clk_src ? XTAL_TICK : RC_TICK;
  assign unit_len = PRE_W'(UNIT_TICKS) << st.exponent;
  assign unit = st.cfg[CFG_ENABLE] && tick && (st.pre == unit_len - 1'b1);
  // mantissa of zero behaves as one rather than never expiring
  assign expire = unit && (17'(st.mcnt) + 17'd1 >= 17'(st.mantissa));
  assign window_end = unit && (9'(st.wcnt) + 9'd1 >= 9'(st.window));
  assign recal_last = (8'h01 << st.cfg[CFG_RECAL_LSB +: 3]) - 8'h01;
  assign cal_start = st.cal_pend && !cal_busy && !SHUTDOWN;

  always_comb begin
    rd_clear = 2'b00;
    if (RD && (ADDR == OFS_INT_STATUS || ADDR == OFS_FAST_STATUS)) begin
      rd_clear = 2'b11;
    end
  end

  always_comb begin
    next_st = st;
    set_flags = 2'b00;

    // wake counter, reload on every expiry
    if (!st.cfg[CFG_ENABLE]) begin
      next_st.pre = '0;
      next_st.mcnt = 16'h0000;
    end else if (tick) begin
      next_st.pre = unit ? '0 : st.pre + 1'b1;
      if (expire) begin
        next_st.mcnt = 16'h0000;
      end else if (unit) begin
        next_st.mcnt = st.mcnt + 16'h0001;
      end
    end

    if (expire) begin
      set_flags[ST_WAKE] = 1'b1;
    end

    // battery compare at each expiry
    if (expire && st.cfg[CFG_BATT]) begin
      // codes count 50 mV steps above 1.5 V, so a plain compare works
      next_st.batt_low = (BATT_LEVEL < st.thr);
      if (BATT_LEVEL < st.thr && !st.cfg[CFG_BATT_PIN]) begin
        set_flags[ST_BATT] = 1'b1;
      end
    end
    if (!st.cfg[CFG_ENABLE] || !st.cfg[CFG_BATT]) begin
      next_st.batt_low = 1'b0;
    end

    // periodic recalibration
    if (expire && st.cfg[CFG_CAL]) begin
      if (st.recal_cnt >= recal_last) begin
        next_st.recal_cnt = 8'h00;
        next_st.cal_pend = 1'b1;
      end else begin
        next_st.recal_cnt = st.recal_cnt + 8'h01;
      end
    end
    if (cal_start) begin
      next_st.cal_pend = 1'b0;
    end

    // duty-cycled listen windows
    case (st.lst)
      L_IDLE: begin
        if (expire && st.cfg[CFG_LISTEN]) begin
          next_st.lst = L_WINDOW;
          next_st.wcnt = 8'h00;
          next_st.seen = 1'b0;
        end
      end
      L_WINDOW: begin
        if (PREAMBLE_OK) begin
          next_st.seen = 1'b1;
        end
        if (PKT_DONE) begin
          next_st.lst = L_IDLE;
        end else if (window_end) begin
          next_st.wcnt = 8'h00;
          if (st.seen || PREAMBLE_OK) begin
            next_st.lst = L_EXTEND;
          end else begin
            next_st.lst = L_IDLE;
          end
        end else if (unit) begin
          next_st.wcnt = st.wcnt + 8'h01;
        end
      end
      L_EXTEND: begin
        if (PKT_DONE || window_end) begin
          next_st.lst = L_IDLE;
        end else if (unit) begin
          next_st.wcnt = st.wcnt + 8'h01;
        end
      end
      default: begin
        next_st.lst = L_IDLE;
      end
    endcase
    if (!st.cfg[CFG_ENABLE] || !st.cfg[CFG_LISTEN]) begin
      next_st.lst = L_IDLE;
    end

    // register writes
    if (WR) begin
      case (ADDR)
        OFS_CONFIG: next_st.cfg = WDATA;
        OFS_EXPONENT: next_st.exponent = WDATA[EXP_W-1:0];
        OFS_MANT_HI: next_st.mantissa[15:8] = WDATA;
        OFS_MANT_LO: next_st.mantissa[7:0] = WDATA;
        OFS_LISTEN: next_st.window = WDATA;
        OFS_BATT_THR: next_st.thr = WDATA[4:0];
        OFS_INT_EN: next_st.int_en = WDATA[1:0];
        OFS_CLK_SRC: next_st.clk_src = WDATA[0];
        OFS_COMMAND: begin
          if (WDATA[CMD_BOOT]) begin
            next_st.cal_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // register reads, data one cycle later
    next_st.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        OFS_CONFIG: next_st.rdata = st.cfg;
        OFS_EXPONENT: next_st.rdata = 8'(st.exponent);
        OFS_MANT_HI: next_st.rdata = st.mantissa[15:8];
        OFS_MANT_LO: next_st.rdata = st.mantissa[7:0];
        OFS_LISTEN: next_st.rdata = st.window;
        OFS_BATT_THR: next_st.rdata = {3'b000, st.thr};
        OFS_INT_EN: next_st.rdata = {6'h00, st.int_en};
        OFS_INT_STATUS: next_st.rdata = {6'h00, st.status};
        OFS_FAST_STATUS: next_st.rdata = {6'h00, st.status};
        OFS_STATE: next_st.rdata = {cal_busy, st.batt_low, st.seen, st.lst != L_IDLE,
          st.cal_pend, st.clk_src, 2'(st.lst)};
        OFS_CLK_SRC: next_st.rdata = {7'h00, st.clk_src};
        default: next_st.rdata = 8'h00;
      endcase
    end

    // sticky flags: a new event wins over the read that clears
    next_st.status = (st.status & ~rd_clear) | set_flags;

    // shutdown wipes all settings; its release asks for calibration
    next_st.shut_q = SHUTDOWN;
    if (SHUTDOWN) begin
      next_st = RST_ST;
      next_st.shut_q = 1'b1;
    end else if (st.shut_q) begin
      next_st.cal_pend = 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // calibration engine
  rc_cal #(
    .COUNT_W(16)
  ) u_cal (
    .clk(MCLK),
    .rst(RESET),
    .clear(SHUTDOWN),
    .start(cal_start),
    .busy(cal_busy),
    .rc_tick(RC_TICK),
    .xo_ready(XO_READY),
    .xo_en(XO_EN),
    .trim(RC_TRIM)
  );

  // ==========================================================
  // outputs
  assign RDATA = st.rdata;
  assign RX_ON = (st.lst != L_IDLE);
  assign LOW_BATT = st.batt_low && st.cfg[CFG_BATT_PIN];
  assign IRQ_N = ~|(st.status & st.int_en);

  // ==========================================================
  // checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  sequence s_expire_listen;
    expire && st.cfg[CFG_LISTEN] && st.lst == L_IDLE && !SHUTDOWN && !WR;
  endsequence

  sequence s_rx_open;
    RX_ON && st.wcnt == 8'h00;
  endsequence

  a_irq_on_wake: assert property (
    (expire && st.int_en[ST_WAKE] && !SHUTDOWN && !WR) |=> !IRQ_N)
    else $error("wake expiry did not pull interrupt low");

  a_flag_latched: assert property (
    (st.status[ST_WAKE] && rd_clear == 2'b00 && !SHUTDOWN) |=> st.status[ST_WAKE])
    else $error("wake flag lost without status read");

  a_read_clears: assert property (
    (RD && ADDR == OFS_INT_STATUS && !expire && !SHUTDOWN) |=> !st.status[ST_WAKE])
    else $error("status read did not clear wake flag");

  a_counter_reload: assert property (
    (expire && !SHUTDOWN && !WR) |=> (st.mcnt == 16'h0000 && st.pre == '0))
    else $error("wake counter not reloaded at expiry");

  a_listen_open: assert property (
    s_expire_listen |=> s_rx_open)
    else $error("listen window did not open at expiry");

  a_idle_stopped: assert property (
    !st.cfg[CFG_ENABLE] |=> (st.pre == '0 && st.mcnt == 16'h0000))
    else $error("wake counter ran while timer disabled");

  a_shutdown_wipe: assert property (
    SHUTDOWN |=> (st.cfg == CONFIG_RST && st.status == 2'b00 && !RX_ON))
    else $error("shutdown left state behind");

  a_batt_gated: assert property (
    $rose(st.status[ST_BATT]) |-> $past(st.cfg[CFG_ENABLE] && st.cfg[CFG_BATT]))
    else $error("battery flag without timer and monitor on");

  a_extend_ends: assert property (
    (st.lst == L_EXTEND && window_end && !SHUTDOWN) |=> !RX_ON)
    else $error("listen kept open past second window");

  a_shutdown_exit_cal: assert property (
    $fell(SHUTDOWN) |-> ##[0:2] (st.cal_pend || XO_EN))
    else $error("no calibration after shutdown exit");

endmodule : wake_timer
`default_nettype wire

//--- sim/host_mcu.sv
`default_nettype none
module host_mcu
  import wake_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // idle bus
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // ==========================================================
  // bus cycles
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : put

  // data lives one cycle only, so sample just after the launching edge
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : get
endmodule : host_mcu
`default_nettype wire

//--- sim/tb_top.sv
`default_nettype none
module tb_top
  import wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic MCLK, RESET, SHUTDOWN, PREAMBLE_OK, PKT_DONE;
  logic RC_TICK = 1'b0;
  logic XTAL_TICK = 1'b0;
  logic XO_READY = 1'b0;
  logic WR, RD, RX_ON, LOW_BATT, XO_EN, IRQ_N;
  logic [4:0] BATT_LEVEL;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA, d;
  logic [6:0] RC_TRIM;
  int fail_count, checked, n, t0, t1;
  int cyc = 0;
  int rc_cnt = 0;
  int xt_cnt = 0;
  int rc_per = 8;
  int xt_per = 12;
  localparam int IRQ = 0;
  localparam int RXS = 1;
  localparam int LB = 2;
  localparam int XO = 3;
  typedef struct { logic src; logic [15:0] mant; logic [3:0] ex; int ticks; } per_s;
  per_s rows[5] = '{'{1'b0, 16'h0001, 4'h0, 4}, '{1'b1, 16'h0003, 4'h1, 24},
    '{1'b0, 16'h0000, 4'h0, 4}, '{1'b1, 16'h0002, 4'h2, 32}, '{1'b0, 16'h0100, 4'h0, 1024}};
  logic [7:0] rst_val[8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

  wake_timer DUT (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .RC_TICK(RC_TICK), .XTAL_TICK(XTAL_TICK),
    .SHUTDOWN(SHUTDOWN), .PREAMBLE_OK(PREAMBLE_OK), .PKT_DONE(PKT_DONE), .RX_ON(RX_ON),
    .BATT_LEVEL(BATT_LEVEL), .LOW_BATT(LOW_BATT), .XO_READY(XO_READY), .XO_EN(XO_EN),
    .RC_TRIM(RC_TRIM), .IRQ_N(IRQ_N));
  host_mcu host (.clk(MCLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD), .rdata(RDATA));

  // ==========================================================
  // clock, ticks, crystal
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  // both sources tick at different rates so the selected one shows in the period
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    rc_cnt <= (rc_cnt >= rc_per - 1) ? 0 : rc_cnt + 1;
    xt_cnt <= (xt_cnt >= xt_per - 1) ? 0 : xt_cnt + 1;
    RC_TICK <= (rc_cnt == rc_per - 1);
    XTAL_TICK <= (xt_cnt == xt_per - 1);
    XO_READY <= XO_EN;
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic sig(input int s);
    case (s)
      IRQ: return IRQ_N;
      RXS: return RX_ON;
      LB: return LOW_BATT;
      default: return XO_EN;
    endcase
  endfunction : sig

  task automatic wt(input int s, input logic v, input int lim, output int k);
    k = 0;
    #1;
    while (sig(s) !== v && k < lim) begin
      @(posedge MCLK);
      #1;
      k++;
    end
  endtask : wt

  task automatic service(input logic [3:0] a, output int t);
    wt(IRQ, 1'b0, 20000, n);
    t = cyc;
    host.get(a, d);
    chk(16'(d[0]), 16'h1);
    chk(16'(IRQ_N), 16'h1);
  endtask : service

  task automatic rx_window(input logic pre, input logic done, output int k);
    wt(RXS, 1'b1, 2000, k);
    t0 = cyc;
    repeat (10) @(posedge MCLK);
    PREAMBLE_OK <= pre;
    @(posedge MCLK);
    PREAMBLE_OK <= 1'b0;
    repeat (10) @(posedge MCLK);
    PKT_DONE <= done;
    @(posedge MCLK);
    PKT_DONE <= 1'b0;
    wt(RXS, 1'b0, 2000, k);
    k = cyc - t0;
  endtask : rx_window

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // watchdog: tests need about 60000 cycles, the slow calibration and the 1024-tick period row most of them
  initial begin
    repeat (90000) @(posedge MCLK);
    fail_count++;
    close_out();
  end

  // ==========================================================
  // tests
  initial begin
    {RESET, SHUTDOWN, PREAMBLE_OK, PKT_DONE} = 4'b1000;
    BATT_LEVEL = 5'd20;
    {fail_count, checked} = '0;
    repeat (6) @(posedge MCLK);
    RESET <= 1'b0;
    foreach (rows[i]) begin
      host.put(OFS_CONFIG, 8'h00);
      host.put(OFS_CLK_SRC, {7'h00, rows[i].src});
      host.put(OFS_EXPONENT, {4'h0, rows[i].ex});
      host.put(OFS_MANT_HI, rows[i].mant[15:8]);
      host.put(OFS_MANT_LO, rows[i].mant[7:0]);
      host.put(OFS_INT_EN, 8'h01);
      host.put(OFS_CONFIG, 8'h01);
      service(OFS_INT_STATUS, t0);
      service(OFS_FAST_STATUS, t1);
      chk(16'(t1 - t0), 16'(rows[i].ticks * (rows[i].src ? xt_per : rc_per)));
      $display("period row %0d done", i);
    end
    // second reset with the timer running and the interrupt pending
    wt(IRQ, 1'b0, 20000, n);
    @(posedge MCLK);
    RESET <= 1'b1;
    @(posedge MCLK);
    #1;
    chk({IRQ_N, RX_ON, LOW_BATT, XO_EN, 5'h00, RC_TRIM}, 16'h8040);
    @(posedge MCLK);
    RESET <= 1'b0;
    host.put(4'hc, 8'hff);
    foreach (rst_val[i]) begin
      host.get((i == 7) ? 4'hc : 4'(i), d);
      chk(16'(d), 16'(rst_val[i]));
    end
    $display("reset test done");
    // listen windows: unit 4 ticks, window 2 units, period 32 ticks
    host.put(OFS_MANT_LO, 8'h08);
    host.put(OFS_LISTEN, 8'h02);
    host.put(OFS_CONFIG, 8'h09);
    rx_window(1'b0, 1'b0, n);
    chk(16'(n), 16'(8 * rc_per));
    rx_window(1'b1, 1'b0, n);
    chk(16'(n), 16'(16 * rc_per));
    rx_window(1'b1, 1'b1, n);
    chk(16'(n < 40), 16'h1);
    $display("listen test done");
    // battery: threshold code 10, level just below and at it
    @(posedge MCLK);
    BATT_LEVEL <= 5'd9;
    host.put(OFS_BATT_THR, 8'h0a);
    host.put(OFS_INT_EN, 8'h02);
    host.put(OFS_CONFIG, 8'h05);
    wt(IRQ, 1'b0, 2000, n);
    host.get(OFS_INT_STATUS, d);
    chk(16'(d[1]), 16'h1);
    host.put(OFS_CONFIG, 8'h15);
    wt(LB, 1'b1, 2000, n);
    chk(16'(LOW_BATT), 16'h1);
    @(posedge MCLK);
    BATT_LEVEL <= 5'd10;
    wt(LB, 1'b0, 2000, n);
    chk(16'(LOW_BATT), 16'h0);
    @(posedge MCLK);
    BATT_LEVEL <= 5'd9;
    wt(LB, 1'b1, 2000, n);
    chk(16'(LOW_BATT), 16'h1);
    host.put(OFS_CONFIG, 8'h14);
    wt(LB, 1'b0, 20, n);
    chk(16'(LOW_BATT), 16'h0);
    $display("battery test done");
    // boot calibration: fast rc trims down, slow rc trims up
    host.put(OFS_COMMAND, 8'h01);
    wt(XO, 1'b1, 6, n);
    chk(16'(XO_EN), 16'h1);
    wt(XO, 1'b0, 40000, n);
    chk(16'(RC_TRIM), 16'h003f);
    rc_per = 800;
    host.put(OFS_COMMAND, 8'h01);
    wt(XO, 1'b1, 6, n);
    wt(XO, 1'b0, 40000, n);
    chk(16'(RC_TRIM), 16'h0040);
    rc_per = 8;
    // periodic recalibration only with its enable
    host.put(OFS_CONFIG, 8'h01);
    wt(XO, 1'b1, 600, n);
    chk(16'(XO_EN), 16'h0);
    host.put(OFS_CONFIG, 8'h03);
    wt(XO, 1'b1, 600, n);
    chk(16'(XO_EN), 16'h1);
    host.put(OFS_CONFIG, 8'h01);
    wt(XO, 1'b0, 2000, n);
    $display("calibration test done");
    // shutdown clears state, loses writes, calibrates on exit
    host.put(OFS_INT_EN, 8'h01);
    wt(IRQ, 1'b0, 2000, n);
    @(posedge MCLK);
    SHUTDOWN <= 1'b1;
    host.put(OFS_INT_EN, 8'h01);
    chk({15'h0000, IRQ_N}, 16'h1);
    SHUTDOWN <= 1'b0;
    wt(XO, 1'b1, 6, n);
    chk(16'(XO_EN), 16'h1);
    host.get(OFS_INT_EN, d);
    chk(16'(d), 16'h0000);
    $display("shutdown test done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
